//--- src/stl_pkg.sv
package stl_pkg;

	// Clocking
	localparam int SYS_CLK_NS        = 100;
	localparam int BIT_CLK_PERIOD_NS = 800;
	localparam int BIT_HALF_CYC      = BIT_CLK_PERIOD_NS / (2 * SYS_CLK_NS);
	localparam logic [7:0] BIT_HALF_LAST = 8'(BIT_HALF_CYC - 1);
	localparam logic [31:0] TIME_STEP    = 32'(SYS_CLK_NS);

	// Frame: start, lock, epoch16, sec32, zero2, ns30, acc8, crc8
	localparam int FRAME_BITS = 98;
	localparam int BODY_BITS  = 89;
	localparam logic [6:0] TX_FIRST = 7'(FRAME_BITS - 1);
	localparam logic [6:0] RX_LAST  = 7'(FRAME_BITS - 2);
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG    = 8'h00;
	localparam logic [7:0] OFS_HB_PERIOD = 8'h04;
	localparam logic [7:0] OFS_TX_W0     = 8'h08;
	localparam logic [7:0] OFS_TX_W1     = 8'h0c;
	localparam logic [7:0] OFS_TX_W2     = 8'h10;
	localparam logic [7:0] OFS_RX_W0     = 8'h14;
	localparam logic [7:0] OFS_RX_W1     = 8'h18;
	localparam logic [7:0] OFS_RX_W2     = 8'h1c;
	localparam logic [7:0] OFS_HB_SAMPLE = 8'h20;
	localparam logic [7:0] OFS_TIME      = 8'h24;
	localparam logic [7:0] OFS_DRIFT     = 8'h28;
	localparam logic [7:0] OFS_SYNC_INTV = 8'h2c;
	localparam logic [7:0] OFS_SYNC_CAP1 = 8'h30;
	localparam logic [7:0] OFS_SYNC_CAP2 = 8'h34;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h38;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h3c;
	localparam logic [7:0] OFS_FREE_RUN  = 8'h40;

	// time_link_config fields
	localparam int CFG_SOURCE    = 0;
	localparam int CFG_SYNC1_OUT = 1;
	localparam int CFG_SYNC2_OUT = 2;
	localparam int CFG_PLL_SEL   = 3;
	localparam int CFG_W         = 4;
	localparam logic [3:0] RST_CONFIG = 4'h0;

	localparam logic [31:0] RST_HB_PERIOD = 32'h0000_2710;
	localparam logic [31:0] RST_SYNC_INTV = 32'h0000_03e8;

	// Received word 2 layout
	localparam int W2_CRC_ERR = 31;
	localparam int W2_LOCK    = 30;

	// Interrupt status bits
	localparam int IRQ_RX   = 0;
	localparam int IRQ_CRC  = 1;
	localparam int IRQ_CAP1 = 2;
	localparam int IRQ_CAP2 = 3;
	localparam int IRQ_TX   = 4;
	localparam int IRQ_W    = 5;

	function automatic logic [7:0] crc8(input logic [BODY_BITS-1:0] d);
		logic [7:0] c;
		logic       fb;
		c = CRC_INIT;
		for (int i = BODY_BITS - 1; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// Words {w0,w1,w2} to a full frame with start bit and check value
	function automatic logic [FRAME_BITS-1:0] frame_from_words(
		input logic [31:0] w0,
		input logic [31:0] w1,
		input logic [31:0] w2
	);
		logic [BODY_BITS-1:0] body;
		body = {w2[W2_LOCK], w0[31:16], w1, 2'b00, w2[29:0], w0[15:8]};
		return {1'b1, body, crc8(body)};
	endfunction

	// Frame without start bit to {w0,w1,w2}, with mismatch flag
	function automatic logic [95:0] frame_to_words(
		input logic [FRAME_BITS-2:0] f
	);
		logic err;
		err = (crc8(f[96:8]) != f[7:0]);
		return {f[95:80], f[15:8], f[7:0], f[79:48], err, f[96], f[45:16]};
	endfunction

endpackage

//--- src/stl_link_if.sv
interface stl_link_if;
	logic dev_bclk;
	logic dev_bclk_oe;
	logic dev_hb;
	logic dev_hb_oe;
	logic dev_code;
	logic dev_code_oe;
	logic host_bclk;
	logic host_bclk_oe;
	logic host_hb;
	logic host_hb_oe;
	logic host_code;
	logic host_code_oe;
	logic bclk;
	logic hb;
	logic code;

	// Resolved wire levels; undriven wires read low
	assign bclk = dev_bclk_oe ? dev_bclk : (host_bclk_oe & host_bclk);
	assign hb   = dev_hb_oe ? dev_hb : (host_hb_oe & host_hb);
	assign code = dev_code_oe ? dev_code : (host_code_oe & host_code);

	modport dev (
		output dev_bclk, dev_bclk_oe, dev_hb, dev_hb_oe,
		output dev_code, dev_code_oe,
		input  bclk, hb, code
	);
	modport host (
		output host_bclk, host_bclk_oe, host_hb, host_hb_oe,
		output host_code, host_code_oe,
		input  bclk, hb, code
	);
endinterface

//--- src/stl_device.sv
// Behaviour
// RULE_01 - All logic runs on reference clock domain
// RULE_02 - Sync input rising edge captures timer
// RULE_03 - Sync output toggles at programmed interval
// RULE_04 - Three-wire link, source or sink by config
// RULE_05 - Sink mode: partner drives one frame per heartbeat
// RULE_06 - Frame field order fixed, start through check
// RULE_07 - Check covers lock through accuracy bits
// RULE_08 - Frame time refers to preceding heartbeat edge
// RULE_09 - Received bits stored in three words
// RULE_10 - Check mismatch flagged in third word
// RULE_11 - Heartbeat edge samples free-running counter
// RULE_12 - Pairs readable; drift corrects time counter
// RULE_13 - Source mode: heartbeat starts frame from image
// RULE_14 - Heartbeat rate set by period control
// RULE_15 - Check value sent right after accuracy
// RULE_16 - Bit clock from own domain or PLL
// RULE_17 - MSB first; change on fall, sample rise
// RULE_18 - Heartbeat edge restarts hunt for start bit
//
// Register access over APB and the register addresses were left to the implementer.
module stl_device (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic [7:0]  i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq,
	input  wire logic [1:0]  i_ext_sync,
	output logic      [1:0]  o_ext_sync,
	output logic      [1:0]  o_ext_sync_oe,
	input  wire logic        i_pll_clk,
	stl_link_if.dev          link
);

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_HUNT = 3'b010,
		RX_DATA = 3'b100
	} stl_rx_state_type;

	logic [stl_pkg::CFG_W-1:0]      time_link_config;
	logic [31:0]                    heartbeat_period_ctrl;
	logic [31:0]                    sync_interval;
	logic [31:0]                    transmit_time_image [3];
	logic [31:0]                    received_time_words [3];
	logic [31:0]                    hb_sample;
	logic [31:0]                    free_run;
	logic [31:0]                    time_cnt;
	logic [31:0]                    sync_cap [2];
	logic [stl_pkg::IRQ_W-1:0]      irq_status;
	logic [stl_pkg::IRQ_W-1:0]      irq_mask;
	logic [stl_pkg::IRQ_W-1:0]      irq_event;
	logic [1:0]                     cap_event;
	logic [31:0]                    rd_data;
	logic                           rd_hit;
	logic                           wr_en;
	logic                           setup;
	logic                           source;
	logic [2:0]                     bclk_s;
	logic [2:0]                     hb_s;
	logic [1:0]                     code_s;
	logic [1:0]                     pll_s;
	logic                           bclk_rise;
	logic                           hb_rise;
	logic [7:0]                     div_cnt;
	logic                           next_bclk;
	logic                           tx_fall;
	logic [31:0]                    hb_cnt;
	logic                           hb_pending;
	logic [stl_pkg::FRAME_BITS-1:0] tx_sh;
	logic [6:0]                     tx_cnt;
	logic                           tx_done;
	stl_rx_state_type               rx_state;
	logic [stl_pkg::FRAME_BITS-2:0] rx_sh;
	logic [6:0]                     rx_cnt;
	logic                           rx_done;
	logic [95:0]                    rx_words;

	assign source = time_link_config[stl_pkg::CFG_SOURCE];
	assign setup  = i_psel & ~i_penable;
	assign wr_en  = i_psel & i_penable & o_pready & i_pwrite;

	// APB slave: one wait-free access phase after setup
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		case (i_paddr)
			stl_pkg::OFS_CONFIG:    rd_data = 32'(time_link_config);
			stl_pkg::OFS_HB_PERIOD: rd_data = heartbeat_period_ctrl;
			stl_pkg::OFS_TX_W0:     rd_data = transmit_time_image[0];
			stl_pkg::OFS_TX_W1:     rd_data = transmit_time_image[1];
			stl_pkg::OFS_TX_W2:     rd_data = transmit_time_image[2];
			stl_pkg::OFS_RX_W0:     rd_data = received_time_words[0]; // RULE_09
			stl_pkg::OFS_RX_W1:     rd_data = received_time_words[1];
			stl_pkg::OFS_RX_W2:     rd_data = received_time_words[2]; // RULE_10
			stl_pkg::OFS_HB_SAMPLE: rd_data = hb_sample; // RULE_12
			stl_pkg::OFS_TIME:      rd_data = time_cnt;
			stl_pkg::OFS_DRIFT:     rd_data = 32'h0000_0000;
			stl_pkg::OFS_SYNC_INTV: rd_data = sync_interval;
			stl_pkg::OFS_SYNC_CAP1: rd_data = sync_cap[0]; // RULE_02
			stl_pkg::OFS_SYNC_CAP2: rd_data = sync_cap[1];
			stl_pkg::OFS_IRQ_STAT:  rd_data = 32'(irq_status);
			stl_pkg::OFS_IRQ_MASK:  rd_data = 32'(irq_mask);
			stl_pkg::OFS_FREE_RUN:  rd_data = free_run;
			default:                rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & ~rd_hit;
			o_prdata  <= (setup & ~i_pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			time_link_config      <= stl_pkg::RST_CONFIG;
			heartbeat_period_ctrl <= stl_pkg::RST_HB_PERIOD;
			sync_interval         <= stl_pkg::RST_SYNC_INTV;
			irq_mask              <= '0;
			for (int i = 0; i < 3; i++) begin
				transmit_time_image[i] <= 32'h0000_0000;
			end
		end else if (wr_en) begin
			case (i_paddr)
				stl_pkg::OFS_CONFIG: begin
					time_link_config <= i_pwdata[stl_pkg::CFG_W-1:0]; // RULE_04
				end
				stl_pkg::OFS_HB_PERIOD: heartbeat_period_ctrl <= i_pwdata;
				stl_pkg::OFS_TX_W0:     transmit_time_image[0] <= i_pwdata;
				stl_pkg::OFS_TX_W1:     transmit_time_image[1] <= i_pwdata;
				stl_pkg::OFS_TX_W2:     transmit_time_image[2] <= i_pwdata;
				stl_pkg::OFS_SYNC_INTV: sync_interval <= i_pwdata;
				stl_pkg::OFS_IRQ_MASK:  irq_mask <= i_pwdata[stl_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Interrupts: sticky, write one to clear, a new event wins
	assign irq_event = {tx_done, cap_event,
		rx_done & rx_words[stl_pkg::W2_CRC_ERR], rx_done}; // RULE_10
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			irq_status <= '0;
			o_irq      <= 1'b0;
		end else begin
			if (wr_en && i_paddr == stl_pkg::OFS_IRQ_STAT) begin
				irq_status <= (irq_status & ~i_pwdata[stl_pkg::IRQ_W-1:0])
					| irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
			o_irq <= |(irq_status & irq_mask);
		end
	end

	// Free-running count and drift-corrected time of day
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			free_run <= 32'h0000_0000;
			time_cnt <= 32'h0000_0000;
		end else begin
			free_run <= free_run + 32'h0000_0001;
			if (wr_en && i_paddr == stl_pkg::OFS_DRIFT) begin
				time_cnt <= time_cnt + stl_pkg::TIME_STEP + i_pwdata; // RULE_12
			end else begin
				time_cnt <= time_cnt + stl_pkg::TIME_STEP;
			end
		end
	end

	// External sync pins: capture on input edge, toggle as output
	for (genvar k = 0; k < 2; k++) begin : g_ext_sync
		logic [2:0]  es_s;
		logic [31:0] es_cnt;
		logic        es_out;
		assign es_out = time_link_config[stl_pkg::CFG_SYNC1_OUT + k];
		always_ff @(posedge i_sys_clk) begin
			if (i_srst) begin
				es_s             <= 3'h0;
				es_cnt           <= 32'h0000_0000;
				sync_cap[k]      <= 32'h0000_0000;
				cap_event[k]     <= 1'b0;
				o_ext_sync[k]    <= 1'b0;
				o_ext_sync_oe[k] <= 1'b0;
			end else begin
				es_s             <= {es_s[1:0], i_ext_sync[k]};
				o_ext_sync_oe[k] <= es_out;
				cap_event[k]     <= ~es_out & es_s[1] & ~es_s[2];
				if (~es_out && es_s[1] && !es_s[2]) begin
					sync_cap[k] <= time_cnt; // RULE_02
				end
				if (es_out && es_cnt >= sync_interval - 32'h0000_0001) begin
					es_cnt        <= 32'h0000_0000;
					o_ext_sync[k] <= ~o_ext_sync[k]; // RULE_03
				end else if (es_out) begin
					es_cnt <= es_cnt + 32'h0000_0001;
				end
			end
		end
	end

	// Pin synchronisers (first stage feeds only the second)
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			bclk_s <= 3'h0;
			hb_s   <= 3'h0;
			code_s <= 2'h0;
			pll_s  <= 2'h0;
		end else begin
			bclk_s <= {bclk_s[1:0], link.bclk}; // RULE_01
			hb_s   <= {hb_s[1:0], link.hb};
			code_s <= {code_s[0], link.code};
			pll_s  <= {pll_s[0], i_pll_clk};
		end
	end
	assign bclk_rise = bclk_s[1] & ~bclk_s[2];
	assign hb_rise   = hb_s[1] & ~hb_s[2];

	// Source bit clock: divider of the reference clock or PLL clock
	always_comb begin
		if (time_link_config[stl_pkg::CFG_PLL_SEL]) begin
			next_bclk = pll_s[1]; // RULE_16
		end else if (div_cnt == stl_pkg::BIT_HALF_LAST) begin
			next_bclk = ~link.dev_bclk; // RULE_16
		end else begin
			next_bclk = link.dev_bclk;
		end
	end
	assign tx_fall = source & link.dev_bclk & ~next_bclk;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			div_cnt          <= 8'h00;
			link.dev_bclk    <= 1'b0;
			link.dev_bclk_oe <= 1'b0;
			link.dev_hb_oe   <= 1'b0;
			link.dev_code_oe <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == stl_pkg::BIT_HALF_LAST) ? 8'h00
				: div_cnt + 8'h01;
			link.dev_bclk    <= source & next_bclk;
			link.dev_bclk_oe <= source; // RULE_04
			link.dev_hb_oe   <= source;
			link.dev_code_oe <= source;
		end
	end

	// Heartbeat generation and frame shifting
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			hb_cnt        <= 32'h0000_0000;
			hb_pending    <= 1'b0;
			link.dev_hb   <= 1'b0;
			link.dev_code <= 1'b0;
			tx_sh         <= '0;
			tx_cnt        <= 7'h00;
			tx_done       <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (!source) begin
				hb_cnt     <= 32'h0000_0000;
				hb_pending <= 1'b0;
			end else if (hb_cnt >= heartbeat_period_ctrl - 32'h0000_0001) begin
				hb_cnt     <= 32'h0000_0000; // RULE_14
				hb_pending <= 1'b1;
			end else begin
				hb_cnt <= hb_cnt + 32'h0000_0001;
			end
			if (!source) begin
				link.dev_hb   <= 1'b0;
				link.dev_code <= 1'b0;
				tx_cnt        <= 7'h00;
			end else if (tx_fall && hb_pending) begin
				hb_pending    <= 1'b0;
				link.dev_hb   <= 1'b1;
				tx_sh         <= stl_pkg::frame_from_words( // RULE_13 RULE_15
					transmit_time_image[0], transmit_time_image[1],
					transmit_time_image[2]) << 1;
				link.dev_code <= 1'b1; // RULE_06
				tx_cnt        <= stl_pkg::TX_FIRST;
			end else if (tx_fall) begin
				link.dev_hb <= 1'b0;
				if (tx_cnt != 7'h00) begin
					link.dev_code <= tx_sh[stl_pkg::FRAME_BITS-1]; // RULE_17
					tx_sh         <= tx_sh << 1;
					tx_cnt        <= tx_cnt - 7'h01;
					tx_done       <= (tx_cnt == 7'h01);
				end else begin
					link.dev_code <= 1'b0;
				end
			end
		end
	end

	// Receiver and heartbeat sampling
	assign rx_words = stl_pkg::frame_to_words({rx_sh[95:0], code_s[1]});
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			rx_state  <= RX_IDLE;
			rx_sh     <= '0;
			rx_cnt    <= 7'h00;
			rx_done   <= 1'b0;
			hb_sample <= 32'h0000_0000;
			for (int i = 0; i < 3; i++) begin
				received_time_words[i] <= 32'h0000_0000;
			end
		end else begin
			rx_done <= 1'b0;
			if (hb_rise) begin
				hb_sample <= free_run; // RULE_11 RULE_08
			end
			if (source) begin
				rx_state <= RX_IDLE;
			end else if (hb_rise) begin
				rx_state <= RX_HUNT; // RULE_18
				rx_cnt   <= 7'h00;
			end else if (bclk_rise) begin
				case (rx_state)
					RX_HUNT: begin
						if (code_s[1]) begin
							rx_state <= RX_DATA; // RULE_18
						end
					end
					RX_DATA: begin
						rx_sh  <= {rx_sh[95:0], code_s[1]}; // RULE_17
						rx_cnt <= rx_cnt + 7'h01;
						if (rx_cnt == stl_pkg::RX_LAST) begin
							rx_state               <= RX_IDLE;
							rx_done                <= 1'b1;
							received_time_words[0] <= rx_words[95:64]; // RULE_09
							received_time_words[1] <= rx_words[63:32];
							received_time_words[2] <= rx_words[31:0]; // RULE_10 RULE_07
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

endmodule // stl_device

//--- src/stl_host.sv
module stl_host (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic        i_source,
	input  wire logic [31:0] i_hb_period,
	input  wire logic [31:0] i_tx_word0,
	input  wire logic [31:0] i_tx_word1,
	input  wire logic [31:0] i_tx_word2,
	output logic             o_tx_done,
	output logic             o_rx_valid,
	output logic      [31:0] o_rx_word0,
	output logic      [31:0] o_rx_word1,
	output logic      [31:0] o_rx_word2,
	stl_link_if.host         link
);

	typedef enum logic [2:0] {
		HR_IDLE = 3'b001,
		HR_HUNT = 3'b010,
		HR_DATA = 3'b100
	} stl_host_rx_type;

	logic [2:0]                     bclk_s;
	logic [2:0]                     hb_s;
	logic [1:0]                     code_s;
	logic [7:0]                     div_cnt;
	logic                           tx_fall;
	logic [31:0]                    hb_cnt;
	logic                           hb_pending;
	logic [stl_pkg::FRAME_BITS-1:0] tx_sh;
	logic [6:0]                     tx_cnt;
	stl_host_rx_type                rx_state;
	logic [stl_pkg::FRAME_BITS-2:0] rx_sh;
	logic [6:0]                     rx_cnt;
	logic [95:0]                    rx_words;

	assign tx_fall = i_source & link.host_bclk
		& (div_cnt == stl_pkg::BIT_HALF_LAST);

	// Drives the link as time source (RULE_05)
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			div_cnt           <= 8'h00;
			link.host_bclk    <= 1'b0;
			link.host_bclk_oe <= 1'b0;
			link.host_hb_oe   <= 1'b0;
			link.host_code_oe <= 1'b0;
			link.host_hb      <= 1'b0;
			link.host_code    <= 1'b0;
			hb_cnt            <= 32'h0000_0000;
			hb_pending        <= 1'b0;
			tx_sh             <= '0;
			tx_cnt            <= 7'h00;
			o_tx_done         <= 1'b0;
		end else begin
			o_tx_done         <= 1'b0;
			link.host_bclk_oe <= i_source;
			link.host_hb_oe   <= i_source;
			link.host_code_oe <= i_source;
			div_cnt <= (div_cnt == stl_pkg::BIT_HALF_LAST) ? 8'h00
				: div_cnt + 8'h01;
			if (div_cnt == stl_pkg::BIT_HALF_LAST) begin
				link.host_bclk <= i_source & ~link.host_bclk;
			end
			if (!i_source) begin
				hb_cnt     <= 32'h0000_0000;
				hb_pending <= 1'b0;
			end else if (hb_cnt >= i_hb_period - 32'h0000_0001) begin
				hb_cnt     <= 32'h0000_0000;
				hb_pending <= 1'b1;
			end else begin
				hb_cnt <= hb_cnt + 32'h0000_0001;
			end
			if (!i_source) begin
				link.host_hb   <= 1'b0;
				link.host_code <= 1'b0;
				tx_cnt         <= 7'h00;
			end else if (tx_fall && hb_pending) begin
				hb_pending     <= 1'b0;
				link.host_hb   <= 1'b1;
				tx_sh          <= stl_pkg::frame_from_words( // RULE_06 RULE_07
					i_tx_word0, i_tx_word1, i_tx_word2) << 1;
				link.host_code <= 1'b1;
				tx_cnt         <= stl_pkg::TX_FIRST;
			end else if (tx_fall) begin
				link.host_hb <= 1'b0;
				if (tx_cnt != 7'h00) begin
					link.host_code <= tx_sh[stl_pkg::FRAME_BITS-1]; // RULE_17
					tx_sh          <= tx_sh << 1;
					tx_cnt         <= tx_cnt - 7'h01;
					o_tx_done      <= (tx_cnt == 7'h01); // RULE_05
				end else begin
					link.host_code <= 1'b0;
				end
			end
		end
	end

	// Receives frames when the device is the source
	assign rx_words = stl_pkg::frame_to_words({rx_sh[95:0], code_s[1]});
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			bclk_s     <= 3'h0;
			hb_s       <= 3'h0;
			code_s     <= 2'h0;
			rx_state   <= HR_IDLE;
			rx_sh      <= '0;
			rx_cnt     <= 7'h00;
			o_rx_valid <= 1'b0;
			o_rx_word0 <= 32'h0000_0000;
			o_rx_word1 <= 32'h0000_0000;
			o_rx_word2 <= 32'h0000_0000;
		end else begin
			bclk_s     <= {bclk_s[1:0], link.bclk};
			hb_s       <= {hb_s[1:0], link.hb};
			code_s     <= {code_s[0], link.code};
			o_rx_valid <= 1'b0;
			if (i_source) begin
				rx_state <= HR_IDLE;
			end else if (hb_s[1] && !hb_s[2]) begin
				rx_state <= HR_HUNT; // RULE_08
				rx_cnt   <= 7'h00;
			end else if (bclk_s[1] && !bclk_s[2]) begin
				case (rx_state)
					HR_HUNT: begin
						if (code_s[1]) begin
							rx_state <= HR_DATA;
						end
					end
					HR_DATA: begin
						rx_sh  <= {rx_sh[95:0], code_s[1]}; // RULE_17
						rx_cnt <= rx_cnt + 7'h01;
						if (rx_cnt == stl_pkg::RX_LAST) begin
							rx_state   <= HR_IDLE;
							o_rx_valid <= 1'b1;
							o_rx_word0 <= rx_words[95:64];
							o_rx_word1 <= rx_words[63:32];
							o_rx_word2 <= rx_words[31:0]; // RULE_07
						end
					end
					default: rx_state <= HR_IDLE;
				endcase
			end
		end
	end

endmodule // stl_host

//--- verification/stl_checker.sv
module stl_checker (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic dev_bclk_oe,
	input wire logic dev_code_oe,
	input wire logic host_bclk_oe,
	input wire logic host_code_oe,
	input wire logic bclk,
	input wire logic hb,
	input wire logic code
);
	logic       on;
	logic       bclk_q;
	logic       hb_q;
	logic [6:0] cnt;

	assign on = dev_bclk_oe | host_bclk_oe;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst || !on);

	// Bit clock falls since the last heartbeat rise
	always_ff @(posedge i_sys_clk) begin
		bclk_q <= bclk;
		hb_q   <= hb;
		if (i_srst || !on)
			cnt <= 7'h7f;
		else if (hb && !hb_q)
			cnt <= 7'h01;
		else if (!bclk && bclk_q && cnt != 7'h7f)
			cnt <= cnt + 7'h01;
	end

	chk_one_driver: assert property (
		!(dev_bclk_oe && host_bclk_oe) && !(dev_code_oe && host_code_oe))
		else $error("both ends drive the link");
	chk_bclk_low: assert property ($fell(bclk) |-> !bclk[*4])
		else $error("bit clock low half too short");
	chk_bclk_high: assert property (
		$rose(bclk) |-> bclk[*4] ##1 !bclk)
		else $error("bit clock high half wrong");
	chk_hb_width: assert property ($rose(hb) |-> hb[*8] ##1 !hb)
		else $error("heartbeat not one bit period");
	chk_hb_at_fall: assert property ($rose(hb) |-> $fell(bclk))
		else $error("heartbeat not on bit clock fall");
	chk_start_bit: assert property ($rose(hb) |-> code)
		else $error("start bit missing");
	chk_code_edge: assert property ($changed(code) |-> $fell(bclk))
		else $error("code changed off the falling edge");
	chk_crc_idle: assert property (
		$fell(bclk) && cnt == 7'd98 |-> !code)
		else $error("code not idle after check value");
	chk_hb_spacing: assert property ($rose(hb) |-> cnt >= 7'd98)
		else $error("heartbeat cut a frame short");
endmodule // stl_checker

//--- verification/serial_time_code_link_tb.sv
module serial_time_code_link_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        src = 1'b0;
	logic        pll = 1'b0;
	logic        tx_done;
	logic        rx_valid;
	logic [1:0]  sync_in = 2'b00;
	logic [31:0] tw [3] = '{32'h0, 32'h0, 32'h0};
	logic [31:0] rw [3];
	logic [31:0] rd;
	logic        er;
	logic [95:0] ex;
	logic [31:0] t0;
	logic [31:0] dr;
	logic [1:0]  so;
	logic [1:0]  soe;
	int          n;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          seed = 79;

	stl_link_if link ();
	always #50 clk = ~clk;
	always #400 pll = ~pll;

	stl_device stl_device_i (.i_sys_clk(clk), .i_srst(srst), .i_paddr(paddr),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .i_ext_sync(sync_in),
		.o_ext_sync(so), .o_ext_sync_oe(soe), .i_pll_clk(pll),
		.link(link.dev));
	stl_host stl_host_i (.i_sys_clk(clk), .i_srst(srst), .i_source(src),
		.i_hb_period(32'h0000_03e8), .i_tx_word0(tw[0]),
		.i_tx_word1(tw[1]), .i_tx_word2(tw[2]), .o_tx_done(tx_done),
		.o_rx_valid(rx_valid), .o_rx_word0(rw[0]), .o_rx_word1(rw[1]),
		.o_rx_word2(rw[2]), .link(link.host));
	stl_checker stl_checker_i (.i_sys_clk(clk), .i_srst(srst),
		.dev_bclk_oe(link.dev_bclk_oe), .dev_code_oe(link.dev_code_oe),
		.host_bclk_oe(link.host_bclk_oe),
		.host_code_oe(link.host_code_oe), .bclk(link.bclk), .hb(link.hb),
		.code(link.code));

	task automatic summarize();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Stored words {w0, w1, w2} for a frame built from image words
	function automatic logic [95:0] expect3(input logic [31:0] a, b, c);
		logic [88:0] body;
		logic [7:0]  crc;
		body = {c[30], a[31:16], b, 2'b00, c[29:0], a[15:8]};
		crc = 8'h00;
		for (int i = 88; i >= 0; i--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ body[i]) ? 8'h07 : 8'h00);
		return {a[31:8], crc, b, 1'b0, c[30:0]};
	endfunction

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h0000_2710);
		apb(1'b0, 8'h2c, 32'h0);
		check(rd, 32'h0000_03e8);
		apb(1'b0, 8'h44, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1'b1, 8'h04, 32'h0000_03e8);
		apb(1'b1, 8'h3c, 32'h0000_0001);
		// Sync pin 2 as output, toggling every 5 cycles
		apb(1'b1, 8'h2c, 32'h0000_0005);
		apb(1'b1, 8'h00, 32'h0000_0004);
		while (so[1] !== 1'b1) @(posedge clk);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (so[1] !== 1'b0);
		check(n, 32'h0000_0005);
		check({30'h0, soe}, 32'h0000_0002);
		// Host as source, device as sink; pin 1 rises right after time read
		apb(1'b0, 8'h24, 32'h0);
		t0 = rd;
		foreach (tw[i])
			tw[i] <= $random(seed);
		src     <= 1'b1;
		sync_in <= 2'b01;
		while (irq !== 1'b1) @(posedge clk);
		ex = expect3(tw[0], tw[1], tw[2]);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'h14 + 8'(4 * i), 32'h0);
			check(rd, ex[95 - 32 * i -: 32]);
		end
		apb(1'b0, 8'h30, 32'h0);
		check(rd - t0, 32'd4 * stl_pkg::TIME_STEP);
		apb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h0000_0005);
		apb(1'b1, 8'h38, 32'h0000_001f);
		apb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h0);
		check({31'h0, irq}, 32'h0);
		// Device as source, host as sink
		src <= 1'b0;
		foreach (tw[i])
			tw[i] <= $random(seed);
		@(posedge clk);
		for (int i = 0; i < 3; i++)
			apb(1'b1, 8'h08 + 8'(4 * i), tw[i]);
		apb(1'b1, 8'h00, 32'h0000_0001);
		do @(posedge clk); while (rx_valid !== 1'b1);
		ex = expect3(tw[0], tw[1], tw[2]);
		for (int i = 0; i < 3; i++)
			check(rw[i], ex[95 - 32 * i -: 32]);
		check({31'h0, irq}, 32'h0);
		apb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h0000_0010);
		// 97 bit periods of frame plus 13 cycles of sync and bus delay
		apb(1'b0, 8'h20, 32'h0);
		t0 = rd;
		apb(1'b0, 8'h40, 32'h0);
		check(rd - t0, 32'd789);
		// Drift write adds once on top of the per-cycle step
		apb(1'b0, 8'h24, 32'h0);
		t0 = rd;
		dr = $random(seed);
		apb(1'b1, 8'h28, dr);
		apb(1'b0, 8'h24, 32'h0);
		check(rd - t0, 32'd6 * stl_pkg::TIME_STEP + dr);
		summarize();
	end
endmodule // serial_time_code_link_tb
